// ### logic/mclf_pkg.sv
// Package: constants and carriers for the current-limit and lock supervisor
`default_nettype none
package mclf_pkg;
  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_MOTOR   = 4'h1;
  localparam logic [3:0] ADDR_FLAGS   = 4'h2;
  localparam logic [3:0] ADDR_STATUS  = 4'h3;
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_MSK = 4'h5;
  // CTRL fields
  localparam int CTRL_ACC_LSB  = 0;
  localparam int CTRL_LCK_LSB  = 4;
  localparam int CTRL_EN_LSB   = 8;
  localparam int CTRL_AVS_LSB  = 14;
  localparam logic [31:0] CTRL_RST = 32'h0000_3F00;
  // MOTOR fields: phase resistance [7:0], back-EMF constant [15:8]
  localparam int MOT_RES_LSB = 0;
  localparam int MOT_KT_LSB  = 8;
  localparam logic [31:0] MOTOR_RST = 32'h0000_0000;
  // Lock flag bit positions
  localparam int N_COND     = 6;
  localparam int FLG_LCURR  = 0;
  localparam int FLG_NOMOT  = 3;
  localparam int FLG_STUCK  = 5;
  // Interrupt events: six lock flags, overcurrent, drivers released
  localparam int N_EVT      = 8;
  localparam int EVT_OVC    = 6;
  localparam int EVT_HIZ    = 7;
  // Threshold scales
  localparam logic [11:0] ACC_STEP_MA   = 12'h0C8;
  localparam logic [11:0] LCK_STEP_MA   = 12'h190;
  localparam logic [11:0] LCK_BASE_MA   = 12'h190;
  localparam logic [11:0] OVC_LIMIT_MA  = 12'hBB8;
  localparam logic [11:0] NOMOT_MIN_MA  = 12'h08C;
  // Timing
  localparam int LOCK_OFF_MS   = 5;
  localparam int CLK_MHZ       = 100;
  localparam int LOCK_OFF_CYC  = LOCK_OFF_MS * 1000 * CLK_MHZ;
  localparam int SURGE_NS      = 1000;
  localparam int SURGE_CYC     = SURGE_NS * CLK_MHZ / 1000;
  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {
    MCLF_RUN, MCLF_BRAKE, MCLF_HIZ, MCLF_LOCKED
  } mclf_state_t;
  typedef struct packed {
    logic        closed_loop;
    logic        restart;
    logic [11:0] phase_u_ma;
    logic [11:0] lowside_ma;
    logic [15:0] speed;
    logic [19:0] comm_period;
    logic        comm_tick;
    logic        loop_handoff;
    logic [2:0]  ext_lock;
  } mclf_sense_t;
  typedef struct packed {
    logic        drive_en;
    logic        brake;
    logic        cap_active;
    logic [31:0] volt_cap;
  } mclf_drive_t;
endpackage : mclf_pkg
`default_nettype wire

// ### logic/mclf_top.sv
// Current-limit, lock and fault supervisor for a sensorless motor driver
//
// Decided for this implementation: the address-and-strobe port and the register offsets.
`default_nettype none
module mclf_top
  import mclf_pkg::*;
#(
  parameter int LOCK_OFF_CYCLES = LOCK_OFF_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [31:0] rdata_o,
  input  wire mclf_sense_t sense_i,
  output mclf_drive_t      drive_o,
  output logic             irq_o
);
  // --------------------------------------------------------------------------
  // Check defaults
  // --------------------------------------------------------------------------
  // Checks sample on the core clock and sleep through reset
  default clocking mclf_cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [31:0]       ctrl_q;
  logic [31:0]       motor_q;
  logic [N_COND-1:0] flags_q;
  logic [N_EVT-1:0]  irq_st_q;
  logic [N_EVT-1:0]  irq_msk_q;
  mclf_state_t       state_q;
  logic [31:0]       timer_q;
  logic [19:0]       prev_period_q;
  logic              handoff_seen_q;
  logic              ovc_q;

  logic [3:0]        acc_thr;
  logic [2:0]        lck_thr;
  logic [N_COND-1:0] lock_en;
  logic              surge_en;
  logic [7:0]        res_ph;
  logic [7:0]        kt_ph;

  assign acc_thr  = ctrl_q[CTRL_ACC_LSB +: 4];
  assign lck_thr  = ctrl_q[CTRL_LCK_LSB +: 3];
  assign lock_en  = ctrl_q[CTRL_EN_LSB +: N_COND];
  assign surge_en = ctrl_q[CTRL_AVS_LSB];
  assign res_ph   = motor_q[MOT_RES_LSB +: 8];
  assign kt_ph    = motor_q[MOT_KT_LSB +: 8];

  // --------------------------------------------------------------------------
  // Detection
  // --------------------------------------------------------------------------
  logic [N_COND-1:0] cond;
  logic [11:0]       lck_limit;
  logic              ovc_trip;
  logic              act;

  assign lck_limit = 12'(LCK_BASE_MA + 12'(lck_thr) * LCK_STEP_MA);
  assign ovc_trip  = sense_i.lowside_ma > OVC_LIMIT_MA;

  always_comb begin
    cond = '0;
    cond[FLG_LCURR] = sense_i.lowside_ma > lck_limit;
    cond[2:1]       = sense_i.ext_lock[1:0];
    cond[FLG_NOMOT] = handoff_seen_q && sense_i.closed_loop &&
                      !(sense_i.phase_u_ma > NOMOT_MIN_MA);
    cond[4]         = sense_i.ext_lock[2];
    cond[FLG_STUCK] = sense_i.closed_loop && (prev_period_q != 20'h0_0000) &&
                      ({1'b0, sense_i.comm_period} >
                       {prev_period_q, 1'b0});
  end

  assign act = ovc_trip || |(cond & lock_en);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      handoff_seen_q <= 1'b0;
    end else if (sense_i.restart) begin
      handoff_seen_q <= 1'b0;
    end else if (sense_i.loop_handoff) begin
      handoff_seen_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || sense_i.restart) begin
      prev_period_q <= 20'h0_0000;
    end else if (sense_i.comm_tick) begin
      prev_period_q <= sense_i.comm_period;
    end
  end

  // --------------------------------------------------------------------------
  // Fault flags
  // --------------------------------------------------------------------------
  // one flag per condition
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      flags_q <= '0;
    end else if (sense_i.restart) begin
      flags_q <= cond;
    end else begin
      flags_q <= flags_q | cond;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i || sense_i.restart) begin
      ovc_q <= 1'b0;
    end else if (ovc_trip) begin
      ovc_q <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Drive state machine
  // --------------------------------------------------------------------------
  // Brake first so winding current decays before the bridge floats
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      state_q <= MCLF_RUN;
      timer_q <= 32'h0000_0000;
    end else begin
      unique case (state_q)
        MCLF_RUN: begin
          // release on overcurrent, lock or no motor
          if (act) begin
            state_q <= surge_en ? MCLF_BRAKE : MCLF_HIZ;
            timer_q <= 32'h0000_0000;
          end
        end
        MCLF_BRAKE: begin
          if (timer_q >= 32'(SURGE_CYC - 1)) begin
            state_q <= MCLF_HIZ;
            timer_q <= 32'h0000_0000;
          end else begin
            timer_q <= timer_q + 32'h0000_0001;
          end
        end
        MCLF_HIZ: begin
          state_q <= MCLF_LOCKED;
          timer_q <= 32'h0000_0000;
        end
        MCLF_LOCKED: begin
          if (timer_q >= 32'(LOCK_OFF_CYCLES - 1)) begin
            state_q <= MCLF_RUN;
            timer_q <= 32'h0000_0000;
          end else begin
            timer_q <= timer_q + 32'h0000_0001;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Acceleration voltage cap
  // --------------------------------------------------------------------------
  logic [31:0] cap_calc;
  assign cap_calc = 32'(32'(acc_thr) * 32'(ACC_STEP_MA) * 32'(res_ph)) +
                    32'(32'(sense_i.speed) * 32'(kt_ph));

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      drive_o <= '0;
    end else begin
      drive_o.drive_en   <= (state_q == MCLF_RUN) && !act;
      // brake from the trip edge, no float gap
      drive_o.brake      <= (state_q == MCLF_RUN && act && surge_en) ||
                            (state_q == MCLF_BRAKE &&
                             timer_q < 32'(SURGE_CYC - 1));
      drive_o.cap_active <= sense_i.closed_loop && (acc_thr != 4'h0);
      drive_o.volt_cap   <= cap_calc;
    end
  end

  // --------------------------------------------------------------------------
  // Register bus and interrupts
  // --------------------------------------------------------------------------
  logic [N_EVT-1:0] evt;
  assign evt = {state_q == MCLF_BRAKE || (state_q == MCLF_RUN && act &&
                !surge_en), ovc_trip, cond};

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_q    <= CTRL_RST;
      motor_q   <= MOTOR_RST;
      irq_msk_q <= '0;
    end else if (wr_i) begin
      if (addr_i == ADDR_CTRL) ctrl_q <= wdata_i;
      if (addr_i == ADDR_MOTOR) motor_q <= wdata_i;
      if (addr_i == ADDR_IRQ_MSK) irq_msk_q <= wdata_i[N_EVT-1:0];
    end
  end

  // Set beats write-one-to-clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_st_q <= '0;
    end else begin
      irq_st_q <= (irq_st_q & ~((wr_i && addr_i == ADDR_IRQ_ST) ?
                   wdata_i[N_EVT-1:0] : '0)) | evt;
    end
  end

  assign irq_o = |(irq_st_q & irq_msk_q);

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      rdata_o <= 32'h0000_0000;
    end else if (rd_i) begin
      unique case (addr_i)
        ADDR_CTRL:    rdata_o <= ctrl_q;
        ADDR_MOTOR:   rdata_o <= motor_q;
        ADDR_FLAGS:   rdata_o <= {25'h0, ovc_q, flags_q};
        ADDR_STATUS:  rdata_o <= {30'h0, state_q};
        ADDR_IRQ_ST:  rdata_o <= {24'h0, irq_st_q};
        ADDR_IRQ_MSK: rdata_o <= {24'h0, irq_msk_q};
        default:      rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      rdata_o <= 32'h0000_0000;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  ovc_stop_a : assert property (
    ovc_trip |=> !drive_o.drive_en)
    else $error("overcurrent left drive on");
  ovc_fixed_a : assert property (
    (sense_i.lowside_ma > OVC_LIMIT_MA) |-> act)
    else $error("overcurrent did not trip");
  lock_act_a : assert property (
    (state_q == MCLF_RUN && act) |=> state_q != MCLF_RUN)
    else $error("trip did not leave run");
  ovc_latch_a : assert property (
    (ovc_trip && !sense_i.restart) |=> ovc_q)
    else $error("overcurrent not latched");
  flag_set_a : assert property (
    (|cond && !sense_i.restart) |=> (flags_q & $past(cond)) == $past(cond))
    else $error("flag not set");
  flag_clr_a : assert property (
    (sense_i.restart && cond == '0) |=> flags_q == '0)
    else $error("flags not cleared");
  flag_hold_a : assert property (
    !sense_i.restart |=>
    (flags_q & $past(flags_q)) == $past(flags_q))
    else $error("flag dropped");

  // Release path: brake first, then float
  surge_seq_a : assert property (
    (state_q == MCLF_RUN && act && surge_en) |=> state_q == MCLF_BRAKE)
    else $error("no brake before release");
  brake_first_a : assert property (
    (state_q == MCLF_RUN && act && surge_en) |=>
    (drive_o.brake && !drive_o.drive_en))
    else $error("bridge floated before brake");
  brake_hold_a : assert property (
    (state_q == MCLF_BRAKE) |-> drive_o.brake)
    else $error("brake dropped early");
  hiz_float_a : assert property (
    (state_q == MCLF_HIZ || state_q == MCLF_LOCKED) |->
    (!drive_o.drive_en && !drive_o.brake))
    else $error("drivers not released");
  nomot_stop_a : assert property (
    (state_q == MCLF_RUN && cond[FLG_NOMOT] && lock_en[FLG_NOMOT]) |=>
    !drive_o.drive_en)
    else $error("missing motor kept driving");
  en_gate_a : assert property (
    (state_q == MCLF_RUN && !ovc_trip && (cond & lock_en) == '0)
    |=> state_q == MCLF_RUN)
    else $error("disabled scheme acted");
  retry_run_a : assert property (
    (state_q == MCLF_LOCKED && timer_q >= 32'(LOCK_OFF_CYCLES - 1)) |=>
    state_q == MCLF_RUN)
    else $error("no retry after lock-off");

  // Limiter and detection
  cap_loop_a : assert property (
    !sense_i.closed_loop |=> !drive_o.cap_active)
    else $error("cap in open loop");
  cap_on_a : assert property (
    (sense_i.closed_loop && acc_thr != 4'h0) |=> drive_o.cap_active)
    else $error("cap missing in closed loop");
  run_drive_a : assert property (
    (state_q == MCLF_RUN && !act) |=> drive_o.drive_en)
    else $error("healthy motor not driven");
  lcurr_flag_a : assert property (
    (sense_i.lowside_ma > lck_limit) |=> flags_q[FLG_LCURR])
    else $error("lock current not flagged");
  nomot_flag_a : assert property (
    (handoff_seen_q && sense_i.closed_loop &&
     sense_i.phase_u_ma <= NOMOT_MIN_MA) |=> flags_q[FLG_NOMOT])
    else $error("missing motor not flagged");
  ext_flag_a : assert property (
    (sense_i.ext_lock == 3'h7) |=> (flags_q[4] && flags_q[2] && flags_q[1]))
    else $error("scheme flag not set");
  stuck_lock_a : assert property (
    (sense_i.closed_loop && prev_period_q != 20'h0_0000 &&
     21'(sense_i.comm_period) > 21'(prev_period_q) * 21'h00_0002) |=>
    flags_q[FLG_STUCK])
    else $error("stuck not flagged");
endmodule : mclf_top
`default_nettype wire

// ### testbench/mclf_motor_model.sv
// Power stage and current sense model for the lock supervisor bench
`default_nettype none
module mclf_motor_model
  import mclf_pkg::*;
(
  input  wire mclf_drive_t drive_i,
  input  wire mclf_sense_t cmd_i,
  output mclf_sense_t      sense_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released bridge carries no winding current; brake keeps it flowing
  always_comb begin
    sense_o = cmd_i;
    if (!drive_i.drive_en && !drive_i.brake) begin
      sense_o.lowside_ma = 12'h000;
      sense_o.phase_u_ma = 12'h000;
    end
  end
endmodule : mclf_motor_model
`default_nettype wire

// ### testbench/tb_mclf_top.sv
// Self-checking bench for the current-limit and lock supervisor
`default_nettype none
module tb_mclf_top;
  import mclf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i;
  logic        nrst_i;
  logic [3:0]  addr_i;
  logic [31:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [31:0] rdata_o;
  mclf_sense_t cmd;
  mclf_sense_t sense_i;
  mclf_drive_t drive_o;
  logic        irq_o;
  int          mismatches;
  int          n_compared;

  mclf_top #(.LOCK_OFF_CYCLES(20)) u_dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .sense_i(sense_i), .drive_o(drive_o), .irq_o(irq_o));
  mclf_motor_model u_motor (.drive_i(drive_o), .cmd_i(cmd), .sense_o(sense_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic complete_run();
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i    <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e,
                       input string nm);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(nm, e, rdata_o);
  endtask : rdchk

  task automatic wait_run();
    int k;
    k = 0;
    while (drive_o.drive_en !== 1'b1 && k < 400) begin
      cyc(1);
      k++;
    end
    chk("retry", 1, drive_o.drive_en);
  endtask : wait_run

  task automatic restart();
    @(posedge clk_i);
    cmd.restart <= 1'b1;
    @(posedge clk_i);
    cmd.restart <= 1'b0;
    cyc(2);
  endtask : restart

  task automatic tick(input logic [19:0] p);
    @(posedge clk_i);
    cmd.comm_period <= p;
    cmd.comm_tick   <= 1'b1;
    @(posedge clk_i);
    cmd.comm_tick   <= 1'b0;
    cyc(2);
  endtask : tick

  task automatic t_reset();
    rdchk(ADDR_CTRL, CTRL_RST, "ctrl");
    rdchk(ADDR_FLAGS, 32'h0, "flags");
    rdchk(4'hF, 32'h0, "unmapped");
    chk("irq", 0, irq_o);
  endtask : t_reset

  task automatic t_cap();
    wr(ADDR_MOTOR, 32'h0000_0203);
    rdchk(ADDR_MOTOR, 32'h0000_0203, "motor");
    wr(ADDR_CTRL, CTRL_RST | 32'h2);
    @(posedge clk_i);
    cmd.closed_loop <= 1'b1;
    cmd.speed       <= 16'h0064;
    cyc(3);
    chk("cap", 32'h578, drive_o.volt_cap);
    chk("cap_on", 1, drive_o.cap_active);
    chk("spin", 1, drive_o.drive_en);
    rdchk(ADDR_FLAGS, 32'h0, "flags");
    @(posedge clk_i);
    cmd.closed_loop <= 1'b0;
    cyc(3);
    chk("cap_off", 0, drive_o.cap_active);
  endtask : t_cap

  task automatic t_lock();
    int n;
    wr(ADDR_IRQ_MSK, 32'hFF);
    wr(ADDR_CTRL, CTRL_RST | 32'h4010);
    @(posedge clk_i);
    cmd.lowside_ma <= 12'h320;
    cyc(3);
    chk("at_limit", 1, drive_o.drive_en);
    @(posedge clk_i);
    cmd.lowside_ma <= 12'h321;
    cyc(1);
    chk("stop", 0, drive_o.drive_en);
    cmd.lowside_ma <= 12'h000;
    n = 0;
    while (drive_o.brake === 1'b1 && n < 300) begin
      cyc(1);
      n++;
    end
    chk("brake_len", SURGE_CYC, n);
    chk("hiz", 0, {drive_o.drive_en, drive_o.brake});
    chk("irq_set", 1, irq_o);
    rdchk(ADDR_IRQ_ST, 32'h81, "irq_st");
    rdchk(ADDR_STATUS, 32'h0000_0003, "locked");
    wait_run();
    rdchk(ADDR_FLAGS, 32'h1, "flags");
    wr(ADDR_IRQ_MSK, 32'h0);
    cyc(1);
    chk("irq_mask", 0, irq_o);
    wr(ADDR_IRQ_ST, 32'hFF);
    wr(ADDR_IRQ_MSK, 32'hFF);
    cyc(1);
    chk("irq_clr", 0, irq_o);
    restart();
    rdchk(ADDR_FLAGS, 32'h0, "flags");
  endtask : t_lock

  task automatic t_disabled();
    wr(ADDR_CTRL, 32'h0000_3E10);
    @(posedge clk_i);
    cmd.lowside_ma <= 12'h384;
    cyc(3);
    chk("still", 1, drive_o.drive_en);
    rdchk(ADDR_FLAGS, 32'h1, "flags");
    cmd.lowside_ma <= 12'h000;
    restart();
    rdchk(ADDR_FLAGS, 32'h0, "flags");
  endtask : t_disabled

  task automatic t_ovc();
    wr(ADDR_CTRL, 32'h0000_0070);
    @(posedge clk_i);
    cmd.lowside_ma <= OVC_LIMIT_MA;
    cyc(3);
    chk("ovc_eq", 1, drive_o.drive_en);
    cmd.lowside_ma <= OVC_LIMIT_MA + 12'h001;
    cyc(2);
    chk("ovc", 0, drive_o.drive_en);
    cmd.lowside_ma <= 12'h000;
    rdchk(ADDR_FLAGS, 32'h40, "flags");
    wait_run();
    restart();
  endtask : t_ovc

  task automatic t_nomotor();
    wr(ADDR_CTRL, CTRL_RST);
    @(posedge clk_i);
    cmd.closed_loop  <= 1'b1;
    cmd.phase_u_ma   <= NOMOT_MIN_MA;
    cmd.loop_handoff <= 1'b1;
    @(posedge clk_i);
    cmd.loop_handoff <= 1'b0;
    cyc(2);
    chk("nomot", 0, drive_o.drive_en);
    rdchk(ADDR_FLAGS, 32'h8, "flags");
    cmd.closed_loop <= 1'b0;
    wait_run();
    restart();
  endtask : t_nomotor

  task automatic t_ext();
    @(posedge clk_i);
    cmd.ext_lock <= 3'b111;
    cyc(2);
    chk("ext_stop", 0, drive_o.drive_en);
    cmd.ext_lock <= 3'b000;
    rdchk(ADDR_FLAGS, 32'h16, "flags");
    wait_run();
    restart();
  endtask : t_ext

  task automatic t_stuck();
    cmd.closed_loop <= 1'b1;
    cmd.phase_u_ma  <= 12'h1F4;
    tick(20'h00064);
    tick(20'h000C8);
    chk("twice", 1, drive_o.drive_en);
    tick(20'h00191);
    rdchk(ADDR_FLAGS, 32'h20, "flags");
  endtask : t_stuck

  initial begin
    nrst_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 32'h0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    cmd = '0;
    mismatches = 0;
    n_compared = 0;
    repeat (8) @(posedge clk_i);
    nrst_i <= 1'b1;
    cyc(2);
    t_reset();
    t_cap();
    t_lock();
    t_disabled();
    t_ovc();
    t_nomotor();
    t_ext();
    t_stuck();
    complete_run();
  end

  // Whole run needs a few hundred cycles; the 20000-cycle limit allows more than fifty times that
  initial begin
    #200000;
    mismatches++;
    complete_run();
  end
endmodule : tb_mclf_top
`default_nettype wire
